/* bench/rsc_core_model.sv */
// core model: sleeps on request, wakes on any reset, makes system clock ticks
`timescale 1ns/1ps
`default_nettype none
module rsc_core_model
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// commands and wake cause
	input wire logic sleep_req,
	input wire logic slow_tick,
	input wire logic wake,
	// towards the controller
	output logic core_asleep,
	output logic halt_enter,
	output logic sys_clk_tick
);
	logic phase;
	// halt pulses once; slow clock ticks every other cycle to stretch settle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_asleep <= 1'b0;
			halt_enter <= 1'b0;
			phase <= 1'b0;
			sys_clk_tick <= 1'b0;
		end
		else
		begin
			halt_enter <= sleep_req && !core_asleep;
			core_asleep <= sleep_req || (core_asleep && !wake);
			phase <= !phase;
			sys_clk_tick <= !slow_tick || phase;
		end
	end
endmodule
`default_nettype wire

/* bench/rsc_reset_state_controller_properties.sv */
// port assertions for the reset state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_state_controller_properties
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core side
	input wire logic halt_enter,
	// action pulses
	input wire logic program_counter_clear,
	input wire logic program_counter_low_clear,
	input wire logic stack_pointer_clear,
	input wire logic stack_pointer_to_top,
	input wire logic load_defaults,
	input wire logic interrupts_disable,
	input wire logic watchdog_counter_clear,
	input wire logic timers_off,
	input wire logic ports_to_input,
	input wire logic analog_input_pins_assign,
	// hold and flags
	input wire logic core_hold,
	input wire logic watchdog_timeout_flag,
	input wire logic power_down_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	//////////////////////////////////////////////////////////////////////////////
	AST_SLEEP_WAKE: assert property (stack_pointer_clear |-> watchdog_timeout_flag
		&& power_down_flag && program_counter_clear && !load_defaults)
		else $error("sleep watchdog wake state wrong");
	AST_POR_FLAGS: assert property (stack_pointer_to_top |-> !watchdog_timeout_flag
		&& !power_down_flag && program_counter_clear)
		else $error("power-on flags not cleared");
	AST_POR_PERIPH: assert property (stack_pointer_to_top |-> interrupts_disable
		&& timers_off && ports_to_input && analog_input_pins_assign)
		else $error("power-on peripheral actions missing");
	AST_WDOG_CLEAR: assert property (program_counter_clear |-> watchdog_counter_clear
		&& program_counter_low_clear)
		else $error("watchdog counter not cleared");
	AST_DEFAULTS: assert property (load_defaults |-> interrupts_disable && timers_off
		&& ports_to_input && !stack_pointer_clear)
		else $error("default load incomplete");
	AST_TO_RISE: assert property ($rose(watchdog_timeout_flag) |-> program_counter_clear
		&& !stack_pointer_to_top)
		else $error("timeout flag rose without watchdog reset");
	AST_PD_RISE: assert property ($rose(power_down_flag) |-> stack_pointer_clear
		|| $past(halt_enter))
		else $error("power-down flag rose without cause");
	AST_SHORT_HOLD: assert property (load_defaults |-> !core_hold && $past(core_hold))
		else $error("hold not one cycle before defaults");
	AST_SETTLE_MIN: assert property (stack_pointer_clear |-> core_hold ##1 core_hold)
		else $error("settle shorter than two cycles");
endmodule
bind rsc_reset_state_controller rsc_reset_state_controller_properties props_i (
	.aclk(aclk), .aresetn(aresetn), .halt_enter(halt_enter),
	.program_counter_clear(program_counter_clear),
	.program_counter_low_clear(program_counter_low_clear),
	.stack_pointer_clear(stack_pointer_clear), .stack_pointer_to_top(stack_pointer_to_top),
	.load_defaults(load_defaults), .interrupts_disable(interrupts_disable),
	.watchdog_counter_clear(watchdog_counter_clear), .timers_off(timers_off),
	.ports_to_input(ports_to_input), .analog_input_pins_assign(analog_input_pins_assign),
	.core_hold(core_hold), .watchdog_timeout_flag(watchdog_timeout_flag),
	.power_down_flag(power_down_flag));
`default_nettype wire

/* bench/rsc_reset_state_controller_tb_top.sv */
// testbench for the reset state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_state_controller_tb_top;
	import rsc_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic por = 1'b0, low_v = 1'b0, wdog = 1'b0, sleep_req = 1'b0, slow_tick = 1'b0;
	logic asleep, halt, tick, pcc, pclc, spc, spt, ld, intd, wdc, tmo, pti, ana, hold, tof, pd_flag;
	int n_mismatch = 0, checks_done = 0;
	always #10 aclk = !aclk;
	rsc_reset_state_controller rsc_reset_state_controller_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.power_on_reset_req(por), .low_voltage_reset(low_v), .watchdog_timeout(wdog),
		.core_asleep(asleep), .halt_enter(halt), .sys_clk_tick(tick),
		.program_counter_clear(pcc), .program_counter_low_clear(pclc),
		.stack_pointer_clear(spc), .stack_pointer_to_top(spt), .load_defaults(ld),
		.interrupts_disable(intd), .watchdog_counter_clear(wdc), .timers_off(tmo),
		.ports_to_input(pti), .analog_input_pins_assign(ana), .core_hold(hold),
		.watchdog_timeout_flag(tof), .power_down_flag(pd_flag));
	rsc_core_model rsc_core_model_i (.aclk(aclk), .aresetn(aresetn), .sleep_req(sleep_req),
		.slow_tick(slow_tick), .wake(pcc), .core_asleep(asleep), .halt_enter(halt),
		.sys_clk_tick(tick));
	//////////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// a spent bound ends the run at once
	task bound(input int k);
		if (k >= 200)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask
	// write: address and data offered together, bready held until answer
	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		do
		begin
			@(posedge aclk);
			k++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1) && k < 200);
		bound(k);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [3:0] a);
		int k;
		k = 0;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		do
		begin
			@(posedge aclk);
			k++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1) && k < 200);
		bound(k);
		{rd, resp} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	task go_sleep;
		@(posedge aclk) sleep_req <= 1'b1;
		@(posedge aclk) sleep_req <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// raise cause lines {wdog,low_v,por}, judge pulses, settle ticks and status
	task cause(input logic [2:0] lines, input logic [4:0] st, input int lo, input int hi);
		int k, n;
		{k, n} = 0;
		@(posedge aclk) {wdog, low_v, por} <= lines;
		while (pcc !== 1'b1 && k < 200) begin @(negedge aclk); k++; end
		bound(k);
		check("sp_top", spt, st[3:2] == 2'h0);
		check("sp_clr", spc, st[3:2] == 2'h3);
		check("defaults", ld, st[3:2] != 2'h3);
		check("wdog_clr", wdc, 1'b1);
		check("flag_pins", {pd_flag, tof}, st[1:0]);
		while (hold === 1'b1 && k < 200) begin n += tick; @(negedge aclk); k++; end
		bound(k);
		check("settle", n >= lo && n <= hi, 1'b1);
		@(posedge aclk) {wdog, low_v, por} <= 3'b000;
		repeat (6) @(posedge aclk);
		axi_rd(RSC_ADDR_STATUS);
		check("status", rd[4:0], st);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task t_regs;
		axi_rd(RSC_ADDR_SETTLE);
		check("settle_reg", rd, 32'h0000_0210);
		axi_rd(4'hc);
		check("unmapped_rd", rd, 32'h0000_0000);
		check("unmapped_rresp", resp, RSC_RESP_SLVERR);
		axi_wr(4'hc, 32'h1);
		check("unmapped_wr", resp, RSC_RESP_SLVERR);
		$display("test regs done");
	endtask
	task t_flags;
		go_sleep();
		cause(3'b001, 5'h00, 0, 0);
		go_sleep();
		cause(3'b100, 5'h0f, 15, 16);
		cause(3'b010, 5'h07, 0, 0);
		axi_wr(RSC_ADDR_STATUS, 32'h3);
		cause(3'b100, 5'h09, 0, 0);
		cause(3'b010, 5'h05, 0, 0);
		$display("test flags done");
	endtask
	task t_slow;
		axi_wr(RSC_ADDR_CTRL, 32'h1);
		@(posedge aclk) slow_tick <= 1'b1;
		go_sleep();
		cause(3'b100, 5'h0f, 1, 2);
		axi_rd(RSC_ADDR_CTRL);
		check("ctrl", rd, 32'h1);
		$display("test slow done");
	endtask
	task t_prio;
		cause(3'b011, 5'h00, 0, 0);
		cause(3'b110, 5'h04, 0, 0);
		$display("test prio done");
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_flags();
		t_slow();
		t_prio();
		end_sim();
	end
endmodule
`default_nettype wire

/* rtl/rsc_cause_if.sv */
// interface carrying synchronised reset cause events
`timescale 1ns/1ps
`default_nettype none
interface rsc_cause_if;
	import rsc_pkg::*;
	logic [RSC_NUM_CAUSES-1:0] event_pulse;
	logic [RSC_NUM_CAUSES-1:0] level;
	modport src (output event_pulse, output level);
	modport dst (input event_pulse, input level);
endinterface
`default_nettype wire

/* rtl/rsc_cause_sync.sv */
// three-stage synchroniser and rising-edge detector for reset cause lines
`timescale 1ns/1ps
`default_nettype none
module rsc_cause_sync
	import rsc_pkg::*;
#(
	parameter int WIDTH = RSC_NUM_CAUSES
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// raw cause lines from other domains
	input wire logic [WIDTH-1:0] raw,
	// synchronised events
	rsc_cause_if.src cause
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync_a;
	logic [WIDTH-1:0] sync_b;
	logic [WIDTH-1:0] stable;
	wire [WIDTH-1:0] agree = ~(sync_a ^ sync_b);
	wire [WIDTH-1:0] next_stable = (agree & sync_a) | (~agree & stable);

	// meta is read only by sync_a
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta <= '0;
			sync_a <= '0;
			sync_b <= '0;
			stable <= '0;
		end
		else
		begin
			meta <= raw;
			sync_a <= meta;
			sync_b <= sync_a;
			stable <= next_stable;
		end
	end

	// a change counts once the last two stages agree
	assign cause.event_pulse = next_stable & ~stable;
	assign cause.level = stable;
endmodule
`default_nettype wire

/* rtl/rsc_pkg.sv */
// constants and types shared by the reset state controller files
package rsc_pkg;
	// register byte addresses
	localparam logic [3:0] RSC_ADDR_CTRL = 4'h0;
	localparam logic [3:0] RSC_ADDR_STATUS = 4'h4;
	localparam logic [3:0] RSC_ADDR_SETTLE = 4'h8;
	// control register fields
	localparam int RSC_CTRL_SLOW_OSC = 0;
	localparam logic [31:0] RSC_CTRL_RESET = 32'h0000_0000;
	// status register fields
	localparam int RSC_ST_TIMEOUT = 0;
	localparam int RSC_ST_POWER_DOWN = 1;
	localparam int RSC_ST_CAUSE_LO = 2;
	localparam int RSC_ST_CAUSE_HI = 3;
	localparam int RSC_ST_SETTLING = 4;
	// settle register fields
	localparam int RSC_SET_FAST_LO = 0;
	localparam int RSC_SET_SLOW_LO = 8;
	// settle delay in system clock cycles, upper figure of each printed range
	localparam int RSC_SETTLE_FAST_CYCLES = 16;
	localparam int RSC_SETTLE_SLOW_CYCLES = 2;
	localparam int RSC_SETTLE_W = 5;
	// axi responses
	localparam logic [1:0] RSC_RESP_OKAY = 2'b00;
	localparam logic [1:0] RSC_RESP_SLVERR = 2'b10;
	// number of reset causes carried by the sync interface
	localparam int RSC_NUM_CAUSES = 3;
	localparam int RSC_CAUSE_POR = 0;
	localparam int RSC_CAUSE_LOW_V = 1;
	localparam int RSC_CAUSE_WDOG = 2;

	// recorded cause of the last reset
	typedef enum logic [1:0]
	{
		RSC_KIND_POR = 2'h0,
		RSC_KIND_LOW_V = 2'h1,
		RSC_KIND_WDOG_RUN = 2'h2,
		RSC_KIND_WDOG_SLEEP = 2'h3
	} rsc_kind_t;

	// sequencer states, one-hot
	typedef enum logic [2:0]
	{
		RSC_ST_IDLE = 3'b001,
		RSC_ST_APPLY = 3'b010,
		RSC_ST_SETTLE = 3'b100
	} rsc_state_t;
endpackage

/* rtl/rsc_reset_state_controller.sv */
// reset state controller: cause priority, flags, core actions, axi4-lite registers
// Behaviour
// - sleep watchdog reset clears pc, sp; sets timeout
// - fast oscillator settle waits 15 to 16 cycles
// - slow oscillator settle waits 1 to 2 cycles
// - power-on clears timeout and power-down flags
// - low-voltage reset leaves both flags unchanged
// - running watchdog reset sets timeout, keeps power-down
// - sleep watchdog reset leaves both flags at one
// - power-on zeroes pc and disables all interrupts
// - any reset clears watchdog, counting restarts
// - power-on switches off all timer modules
// - power-on makes ports inputs, analog pins converter
// - power-on points stack pointer at stack top
// - defaults load except sleep watchdog; low pc cleared
// - running watchdog reset equals low-voltage plus timeout
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_state_controller
	import rsc_pkg::*;
#(
	parameter int FAST_SETTLE = RSC_SETTLE_FAST_CYCLES,
	parameter int SLOW_SETTLE = RSC_SETTLE_SLOW_CYCLES
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// reset cause lines from other domains
	input wire logic power_on_reset_req,
	input wire logic low_voltage_reset,
	input wire logic watchdog_timeout,
	// core state, same clock
	input wire logic core_asleep,
	input wire logic halt_enter,
	input wire logic sys_clk_tick,
	// actions towards core and peripherals, one-cycle pulses
	output logic program_counter_clear,
	output logic program_counter_low_clear,
	output logic stack_pointer_clear,
	output logic stack_pointer_to_top,
	output logic load_defaults,
	output logic interrupts_disable,
	output logic watchdog_counter_clear,
	output logic timers_off,
	output logic ports_to_input,
	output logic analog_input_pins_assign,
	// hold level while a reset is being applied or settling
	output logic core_hold,
	// status flags
	output logic watchdog_timeout_flag,
	output logic power_down_flag
);
	////////////////////////////////////////////////////////////////////////
	// cause synchronisation

	rsc_cause_if cause_bus ();

	rsc_cause_sync #(
		.WIDTH(RSC_NUM_CAUSES)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.raw({watchdog_timeout, low_voltage_reset, power_on_reset_req}),
		.cause(cause_bus.src)
	);

	////////////////////////////////////////////////////////////////////////
	// cause priority

	wire ev_por = cause_bus.event_pulse[RSC_CAUSE_POR];
	wire ev_low_v = cause_bus.event_pulse[RSC_CAUSE_LOW_V];
	wire ev_wdog = cause_bus.event_pulse[RSC_CAUSE_WDOG];
	wire any_event = |cause_bus.event_pulse;
	// a lower cause is dropped when a higher one lands in the same cycle
	wire rsc_kind_t event_kind = ev_por ? RSC_KIND_POR :
		ev_low_v ? RSC_KIND_LOW_V :
		(ev_wdog && core_asleep) ? RSC_KIND_WDOG_SLEEP : RSC_KIND_WDOG_RUN;

	////////////////////////////////////////////////////////////////////////
	// sequencer

	rsc_state_t state;
	rsc_state_t next_state;
	rsc_kind_t kind;
	rsc_kind_t last_kind;
	logic [RSC_SETTLE_W-1:0] settle_cnt;
	logic slow_osc;

	localparam logic [RSC_SETTLE_W-1:0] FAST_CNT = RSC_SETTLE_W'(FAST_SETTLE);
	localparam logic [RSC_SETTLE_W-1:0] SLOW_CNT = RSC_SETTLE_W'(SLOW_SETTLE);

	wire in_idle = (state == RSC_ST_IDLE);
	wire in_apply = (state == RSC_ST_APPLY);
	wire in_settle = (state == RSC_ST_SETTLE);
	// a new cause of higher rank restarts the sequence; otherwise it is dropped
	wire take_event = any_event && (in_idle || event_kind < kind);
	wire settle_done = in_settle && sys_clk_tick && settle_cnt == RSC_SETTLE_W'(1);
	wire is_sleep_wdog = (kind == RSC_KIND_WDOG_SLEEP);
	wire is_por = (kind == RSC_KIND_POR);

	// next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			RSC_ST_IDLE:
				if (take_event)
					next_state = RSC_ST_APPLY;
			RSC_ST_APPLY:
				if (take_event)
					next_state = RSC_ST_APPLY;
				else if (is_sleep_wdog)
					next_state = RSC_ST_SETTLE;
				else
					next_state = RSC_ST_IDLE;
			RSC_ST_SETTLE:
				if (take_event)
					next_state = RSC_ST_APPLY;
				else if (settle_done)
					next_state = RSC_ST_IDLE;
			default:
				next_state = RSC_ST_IDLE;
		endcase
	end

	// state, cause register and settle counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= RSC_ST_IDLE;
			kind <= RSC_KIND_POR;
			last_kind <= RSC_KIND_POR;
			settle_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			if (take_event)
			begin
				kind <= event_kind;
				last_kind <= event_kind;
			end
			// the settle count is taken from the oscillator chosen at apply time
			if (in_apply)
				settle_cnt <= slow_osc ? SLOW_CNT : FAST_CNT;
			else if (in_settle && sys_clk_tick)
				settle_cnt <= settle_cnt - RSC_SETTLE_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// action pulses, registered so they appear the cycle after apply

	wire next_defaults = in_apply && !is_sleep_wdog;
	wire next_por_act = in_apply && is_por;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			program_counter_clear <= 1'b0;
			program_counter_low_clear <= 1'b0;
			stack_pointer_clear <= 1'b0;
			stack_pointer_to_top <= 1'b0;
			load_defaults <= 1'b0;
			interrupts_disable <= 1'b0;
			watchdog_counter_clear <= 1'b0;
			timers_off <= 1'b0;
			ports_to_input <= 1'b0;
			analog_input_pins_assign <= 1'b0;
		end
		else
		begin
			program_counter_clear <= in_apply;
			program_counter_low_clear <= in_apply;
			stack_pointer_clear <= in_apply && is_sleep_wdog;
			stack_pointer_to_top <= next_por_act;
			load_defaults <= next_defaults;
			interrupts_disable <= next_defaults;
			watchdog_counter_clear <= in_apply;
			timers_off <= next_defaults;
			ports_to_input <= next_defaults;
			analog_input_pins_assign <= next_defaults;
		end
	end

	// core is held from the apply cycle until settling ends
	assign core_hold = !in_idle;

	////////////////////////////////////////////////////////////////////////
	// flags

	logic wr_clear_to;
	logic wr_clear_pd;
	wire next_to_set = in_apply && !is_por && kind != RSC_KIND_LOW_V;
	wire next_to_clr = in_apply && is_por;
	wire next_pd_set = halt_enter || (in_apply && is_sleep_wdog);
	wire next_pd_clr = in_apply && is_por;

	// a hardware set wins over a software clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			watchdog_timeout_flag <= 1'b0;
			power_down_flag <= 1'b0;
		end
		else
		begin
			if (next_to_set)
				watchdog_timeout_flag <= 1'b1;
			else if (next_to_clr || wr_clear_to)
				watchdog_timeout_flag <= 1'b0;
			if (next_pd_set)
				power_down_flag <= 1'b1;
			else if (next_pd_clr || wr_clear_pd)
				power_down_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire wr_have_addr = aw_held || aw_fire;
	wire wr_have_data = w_held || w_fire;
	wire wr_go = wr_have_addr && wr_have_data && !s_axi_bvalid;
	wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_ctrl = wr_go && wr_addr == RSC_ADDR_CTRL;
	wire wr_status = wr_go && wr_addr == RSC_ADDR_STATUS;
	wire wr_settle = wr_go && wr_addr == RSC_ADDR_SETTLE;
	wire wr_ok = wr_ctrl || wr_status || wr_settle;

	// status flags are write-one-to-clear in byte lane 0
	assign wr_clear_to = wr_status && wr_strb[0] && wr_data[RSC_ST_TIMEOUT];
	assign wr_clear_pd = wr_status && wr_strb[0] && wr_data[RSC_ST_POWER_DOWN];

	// address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RSC_RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
				aw_addr <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			aw_held <= wr_go ? 1'b0 : wr_have_addr;
			w_held <= wr_go ? 1'b0 : wr_have_data;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// oscillator select steers the settle count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			slow_osc <= RSC_CTRL_RESET[RSC_CTRL_SLOW_OSC];
		else if (wr_ctrl && wr_strb[0])
			slow_osc <= wr_data[RSC_CTRL_SLOW_OSC];
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	wire [31:0] ctrl_word = {31'h0, slow_osc};
	wire [31:0] status_word = {27'h0, in_settle, last_kind, power_down_flag,
		watchdog_timeout_flag};
	wire [31:0] settle_word = {16'h0, 3'h0, SLOW_CNT, 3'h0, FAST_CNT};
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire rd_ok = s_axi_araddr == RSC_ADDR_CTRL || s_axi_araddr == RSC_ADDR_STATUS ||
		s_axi_araddr == RSC_ADDR_SETTLE;
	wire [31:0] rd_word = (s_axi_araddr == RSC_ADDR_CTRL) ? ctrl_word :
		(s_axi_araddr == RSC_ADDR_STATUS) ? status_word :
		(s_axi_araddr == RSC_ADDR_SETTLE) ? settle_word : 32'h0000_0000;

	assign s_axi_arready = !s_axi_rvalid;

	// one read outstanding; data held until taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RSC_RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire
